/* File: bench/sbmel_eeprom_model.sv */
/*
 * Two-wire EEPROM model answering at address 1010000b.
 * Assumes resolved open-drain levels with pull-ups on both lines.
 */
module sbmel_eeprom_model (
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256];
	logic [7:0] sh;
	logic [7:0] wa = 8'h00;
	logic       act = 1'b0;
	logic       tx, sel, nak, d;
	int         cnt, nb;
	initial o_sda_oe = 1'b0;
	// ****************************************
	// Start, stop and bit sampling
	// ****************************************
	always @(negedge i_sda) if (i_scl === 1'b1) begin
		act = 1'b1;
		cnt = 0;
		nb = 0;
		tx = 1'b0;
		sel = 1'b0;
	end
	always @(posedge i_sda) if (i_scl === 1'b1) act = 1'b0;
	always @(posedge i_scl) if (act) begin
		if (cnt < 8) sh = {sh[6:0], i_sda};
		else nak = i_sda;
		cnt++;
	end
	// ****************************************
	// Drive only while clock is low
	// ****************************************
	always @(negedge i_scl) if (act) begin
		d = 1'b0;
		if (cnt == 8 && !tx) begin
			if (nb == 0) begin
				sel = (sh[7:1] == 7'h50);
				tx = sh[0];
			end else if (nb == 1) wa = sh;
			else begin
				mem[wa] = sh;
				wa++;
			end
			d = sel;
			nb++;
		end else if (cnt == 8) wa++;
		else if (cnt == 9) begin
			cnt = 0;
			if (tx && nak) sel = 1'b0;
		end
		if (tx && sel && cnt < 8) d = !mem[wa][7 - cnt];
		o_sda_oe = d;
	end
endmodule // sbmel_eeprom_model

/* File: bench/sbmel_serial_master_asserts.sv */
/*
 * Checker for the serial master ports.
 * Assumes it is bound to the top module by the bench.
 */
module sbmel_serial_master_asserts (
	input wire logic                      i_clk,
	input wire logic                      i_nrst,
	input wire logic                      i_link_clk,
	input wire logic                      i_cfg_wr,
	input wire logic [7:0]                i_cfg_addr,
	input wire logic [7:0]                i_cfg_wdata,
	input wire logic [7:0]                o_cfg_rdata,
	input wire logic                      i_power_strap_a,
	input wire logic                      i_power_strap_b,
	input wire logic                      i_multi_pin_one_i,
	input wire logic                      o_multi_pin_one_o,
	input wire logic                      o_multi_pin_one_oe,
	input wire logic                      o_multi_pin_four_o,
	input wire logic                      o_multi_pin_four_oe,
	input wire logic                      o_iface_present,
	input wire sbmel_pkg::sbmel_load_type o_load
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Pin checks
	// ****************************************
	a_pin_out_low: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
		!o_multi_pin_one_o && !o_multi_pin_four_o) else $error("pin output not low");
	a_absent_quiet: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
		!o_iface_present |-> !o_multi_pin_one_oe && !o_multi_pin_four_oe) else $error("pins driven when absent");
	a_start_then_low: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
		$rose(o_multi_pin_one_oe) && !o_multi_pin_four_oe |-> ##[1:120] o_multi_pin_four_oe)
		else $error("start not followed by clock low");
	a_stop_then_idle: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
		$fell(o_multi_pin_one_oe) && !o_multi_pin_four_oe && $past(!o_multi_pin_four_oe)
		|-> !o_multi_pin_four_oe [*8]) else $error("clock moved right after stop");
	a_scl_high_hold: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
		$fell(o_multi_pin_four_oe) |-> !o_multi_pin_four_oe [*8]) else $error("clock high too short");
	a_scl_low_hold: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
		$rose(o_multi_pin_four_oe) |-> o_multi_pin_four_oe [*8]) else $error("clock low too short");
	a_scl_low_bound: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
		$rose(o_multi_pin_four_oe) |-> ##[100:110] !o_multi_pin_four_oe) else $error("clock low phase off rate");
	// ****************************************
	// Register and load checks
	// ****************************************
	a_status_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_cfg_addr == 8'hb3 |=> (o_cfg_rdata & 8'h96) == 8'h00) else $error("status spare bits set");
	a_load_mask: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_load.valid |-> (o_load.data & ~o_load.mask) == 32'h0000_0000) else $error("load data outside mask");
	a_load_map: assert property (@(posedge i_clk) disable iff (!i_nrst) o_load.valid |->
		(o_load.offset == 8'h40 && o_load.mask == 32'hffff_ffff) ||
		(o_load.offset == 8'h80 && o_load.mask == 32'hcd00_c07a) ||
		(o_load.offset == 8'h8c && o_load.mask == 32'h0fff_ffff) ||
		(o_load.offset == 8'h90 && o_load.mask == 32'h9f4f_80c0)) else $error("load offset or mask wrong");
	a_load_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_load.valid |=> !o_load.valid) else $error("load valid longer than one cycle");
	c_load: cover property (@(posedge i_clk) o_load.valid);
	c_start: cover property (@(posedge i_clk) i_cfg_wr && i_cfg_addr == 8'hb2);
	c_sda: cover property (@(posedge i_link_clk) $rose(o_multi_pin_one_oe) && !o_multi_pin_four_oe);
endmodule // sbmel_serial_master_asserts

/* File: bench/test_serial_bus_master_eeprom_loader.sv */
/*
 * Bench for the serial master and loader.
 * Assumes the EEPROM model and the checker are compiled alongside.
 */
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; $display("Error at %0t: mismatch", $time); end end
module test_serial_bus_master_eeprom_loader;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, lclk = 0, nrst = 0, wr = 0, sa = 0, sb = 0;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdv, idx, dv;
	logic one_o, one_oe, four_o, four_oe, pres, m_oe, sda, scl;
	sbmel_pkg::sbmel_load_type ld, got[$];
	int failures = 0, check_count = 0, seed;
	assign sda = !(one_oe || m_oe);
	assign scl = !four_oe;
	initial forever #25 clk = ~clk;
	initial begin
		#7;
		forever #24 lclk = ~lclk;
	end
	sbmel_serial_master dut (.i_clk(clk), .i_nrst(nrst), .i_link_clk(lclk), .i_cfg_wr(wr), .i_cfg_addr(addr),
		.i_cfg_wdata(wd), .o_cfg_rdata(rdv), .i_power_strap_a(sa), .i_power_strap_b(sb),
		.i_multi_pin_one_i(sda), .o_multi_pin_one_o(one_o), .o_multi_pin_one_oe(one_oe),
		.o_multi_pin_four_o(four_o), .o_multi_pin_four_oe(four_oe), .o_iface_present(pres), .o_load(ld));
	sbmel_eeprom_model eeprom (.i_scl(scl), .i_sda(sda), .o_sda_oe(m_oe));
	always @(negedge clk) if (ld.valid === 1'b1) got.push_back(ld);
	// ****************************************
	// Tasks
	// ****************************************
	task automatic end_of_test;
		$display("Checks %0d, failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#2 addr = a;
		wd = d;
		wr = 1'b1;
		@(posedge clk);
		#2 wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		#2 addr = a;
		@(posedge clk);
		#2 v = rdv;
	endtask
	task automatic wait_idle;
		logic [7:0] s;
		int n;
		n = 0;
		rd_reg(8'hb3, s);
		while (s[5] !== 1'b0 && n < 25000) begin
			rd_reg(8'hb3, s);
			n++;
		end
		`CHK(s[5], 1'b0)
	endtask
	task automatic do_reset(input logic a, input logic b);
		nrst = 1'b0;
		sa = a;
		sb = b;
		got.delete();
		repeat (8) @(posedge clk);
		#2 nrst = 1'b1;
		repeat (4) @(posedge clk);
	endtask
	function automatic sbmel_pkg::sbmel_load_type exp_load(input logic [7:0] r, input logic [31:0] d);
		sbmel_pkg::sbmel_load_type e;
		e.valid = 1'b1;
		case (r)
			8'h01: begin e.offset = 8'h40; e.mask = sbmel_pkg::MASK_SUBSYS_ID; end
			8'h02: begin e.offset = 8'h80; e.mask = sbmel_pkg::MASK_SYS_CTRL; end
			8'h03: begin e.offset = 8'h8c; e.mask = sbmel_pkg::MASK_MULTI_ROUTE; end
			default: begin e.offset = 8'h90; e.mask = sbmel_pkg::MASK_COMBINED; end
		endcase
		e.data = d & e.mask;
		return e;
	endfunction
	task automatic load_round(input logic [7:0] r0, r1, r2, st);
		logic [7:0] s;
		sbmel_pkg::sbmel_load_type e;
		for (int i = 0; i < 256; i++) eeprom.mem[i] = 8'($urandom);
		eeprom.mem[0] = r0;
		eeprom.mem[8] = r1;
		eeprom.mem[16] = r2;
		do_reset(1'b1, 1'b1);
		wait_idle();
		`CHK(got.size(), 2)
		for (int k = 0; k < 2; k++) begin
			e = exp_load(eeprom.mem[k * 8], {eeprom.mem[k * 8 + 1], eeprom.mem[k * 8 + 2],
				eeprom.mem[k * 8 + 3], eeprom.mem[k * 8 + 4]});
			`CHK(got[k], e)
		end
		rd_reg(8'hb3, s);
		`CHK(s, st)
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		seed = $urandom(32'hbc22a227);
		load_round(8'h01, 8'h03, 8'hff, 8'h08);
		`CHK(pres, 1'b1)
		wr_reg(8'hb3, 8'h08);
		rd_reg(8'hb3, dv);
		`CHK(dv, 8'h00)
		idx = 8'(8'h40 + $urandom_range(0, 63));
		dv = 8'($urandom);
		wr_reg(8'hb0, dv);
		wr_reg(8'hb1, idx);
		wr_reg(8'hb2, 8'ha0);
		wait_idle();
		`CHK(eeprom.mem[idx], dv)
		idx++;
		eeprom.mem[idx] = ~dv;
		wr_reg(8'hb1, idx);
		wr_reg(8'hb2, 8'ha1);
		wait_idle();
		rd_reg(8'hb0, wd);
		`CHK(wd, ~dv)
		rd_reg(8'hb3, wd);
		`CHK(wd, 8'h00)
		wr_reg(8'hb2, 8'h42);
		wait_idle();
		rd_reg(8'hb3, wd);
		`CHK(wd, 8'h40)
		wr_reg(8'hb3, 8'h40);
		wr_reg(8'hb4, 8'hff);
		rd_reg(8'hb4, wd);
		`CHK(wd, 8'h00)
		rd_reg(8'hb3, wd);
		`CHK(wd, 8'h00)
		load_round(8'h02, 8'h04, 8'h01, 8'h09);
		do_reset(1'b0, 1'b1);
		wr_reg(8'hb2, 8'ha1);
		rd_reg(8'hb3, wd);
		`CHK(wd, 8'h00)
		`CHK(pres, 1'b0)
		end_of_test();
	end
	initial begin
		#5000000;
		failures++;
		end_of_test();
	end
endmodule // test_serial_bus_master_eeprom_loader
bind sbmel_serial_master sbmel_serial_master_asserts u_chk (.i_clk(i_clk), .i_nrst(i_nrst),
	.i_link_clk(i_link_clk), .i_cfg_wr(i_cfg_wr), .i_cfg_addr(i_cfg_addr), .i_cfg_wdata(i_cfg_wdata),
	.o_cfg_rdata(o_cfg_rdata), .i_power_strap_a(i_power_strap_a), .i_power_strap_b(i_power_strap_b),
	.i_multi_pin_one_i(i_multi_pin_one_i), .o_multi_pin_one_o(o_multi_pin_one_o),
	.o_multi_pin_one_oe(o_multi_pin_one_oe), .o_multi_pin_four_o(o_multi_pin_four_o),
	.o_multi_pin_four_oe(o_multi_pin_four_oe), .o_iface_present(o_iface_present), .o_load(o_load));

/* File: rtl/sbmel_pkg.sv */
/*
 * Constants and types for the two-wire serial bus master and its EEPROM loader.
 * Assumes a byte-wide configuration port and a free-running link clock of 48 ns period.
 */
package sbmel_pkg;

	// ****************************************
	// Configuration register offsets and bits
	// ****************************************
	localparam logic [7:0] OFS_SERIAL_DATA_BYTE    = 8'hb0;
	localparam logic [7:0] OFS_SERIAL_WORD_INDEX   = 8'hb1;
	localparam logic [7:0] OFS_SERIAL_TARGET_SEL   = 8'hb2;
	localparam logic [7:0] OFS_SERIAL_CTRL_STATUS  = 8'hb3;
	localparam int         BIT_LOAD_ERR            = 0;
	localparam int         BIT_IFACE_PRESENT       = 3;
	localparam int         BIT_TRANSFER_BUSY       = 5;
	localparam int         BIT_NACK_ERR            = 6;
	localparam int         BIT_DIRECTION_SELECT    = 0;
	localparam logic [7:0] RESET_REG               = 8'h00;

	// ****************************************
	// EEPROM layout
	// ****************************************
	localparam logic [6:0] EEPROM_ADDR             = 7'h50;
	localparam logic [7:0] LIST_TERMINATOR         = 8'hff;
	localparam logic [7:0] REF_SUBSYS_ID           = 8'h01;
	localparam logic [7:0] REF_SYS_CTRL            = 8'h02;
	localparam logic [7:0] REF_MULTI_ROUTE         = 8'h03;
	localparam logic [7:0] REF_COMBINED            = 8'h04;
	localparam logic [7:0] PCI_OFS_SUBSYS_ID       = 8'h40;
	localparam logic [7:0] PCI_OFS_SYS_CTRL        = 8'h80;
	localparam logic [7:0] PCI_OFS_MULTI_ROUTE     = 8'h8c;
	localparam logic [7:0] PCI_OFS_COMBINED        = 8'h90;
	localparam logic [31:0] MASK_SUBSYS_ID         = 32'hffff_ffff;
	localparam logic [31:0] MASK_SYS_CTRL          = 32'hcd00_c07a;
	localparam logic [31:0] MASK_MULTI_ROUTE       = 32'h0fff_ffff;
	localparam logic [31:0] MASK_COMBINED          = 32'h9f4f_80c0;
	localparam logic [7:0] ENTRY_STRIDE            = 8'h08;
	localparam logic [7:0] FIRST_WORD_ADDR         = 8'h00;
	localparam logic [2:0] LAST_DATA_BYTE          = 3'h4;

	// ****************************************
	// Timing
	// ****************************************
	localparam int         SCL_PERIOD_NS           = 10000;
	localparam int         LINK_PERIOD_NS          = 48;
	localparam logic [6:0] QUARTER_CYC             = 7'((SCL_PERIOD_NS / 4 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
	localparam logic [1:0] INIT_ACT                = 2'h2;
	localparam logic [1:0] INIT_DONE               = 2'h3;
	localparam logic [3:0] BITS_PER_SLOT           = 4'h8;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		LS_IDLE  = 2'b00,
		LS_START = 2'b01,
		LS_BYTE  = 2'b11,
		LS_STOP  = 2'b10
	} sbmel_lstate_type;

	typedef enum logic [2:0] {
		SP_ADDRW = 3'h0,
		SP_INDEX = 3'h1,
		SP_WDATA = 3'h2,
		SP_ADDRR = 3'h3,
		SP_RDATA = 3'h4
	} sbmel_step_type;

	typedef struct packed {
		logic       is_load;
		logic       is_read;
		logic [6:0] addr;
		logic [7:0] index;
		logic [7:0] wdata;
	} sbmel_cmd_type;

	typedef struct packed {
		logic [7:0] rx;
		logic       nack_err;
		logic       load_err;
	} sbmel_res_type;

	typedef struct packed {
		logic [7:0]  ref_code;
		logic [31:0] data;
	} sbmel_ldw_type;

	typedef struct packed {
		logic        valid;
		logic [7:0]  offset;
		logic [31:0] data;
		logic [31:0] mask;
	} sbmel_load_type;

	typedef struct packed {
		logic [1:0]     init;
		logic [1:0]     strap_a;
		logic [1:0]     strap_b;
		logic           present;
		logic [7:0]     data;
		logic [7:0]     index;
		logic [7:0]     tsel;
		logic           detect;
		logic           load_err;
		logic           nack_err;
		logic           busy;
		logic           req_tog;
		sbmel_cmd_type  cmd;
		logic [2:0]     done_s;
		logic [2:0]     load_s;
		sbmel_load_type load;
		logic [7:0]     rdata;
	} sbmel_pstate_type;

	typedef struct packed {
		logic [1:0]       rst_s;
		logic [2:0]       req_s;
		logic [1:0]       sda_s;
		sbmel_lstate_type st;
		sbmel_step_type   step;
		logic [6:0]       qcnt;
		logic [1:0]       qph;
		logic [3:0]       bitn;
		logic [7:0]       txb;
		logic [7:0]       rx;
		logic             acked;
		logic [2:0]       nbyte;
		logic [7:0]       prev_ref;
		logic [7:0]       ref_code;
		logic [31:0]      dword;
		logic [7:0]       wa;
		logic             finish;
		sbmel_cmd_type    cmd;
		sbmel_res_type    res;
		sbmel_ldw_type    ldw;
		logic             done_tog;
		logic             load_tog;
		logic             scl;
		logic             sda;
	} sbmel_lstate_all_type;

endpackage

/* File: rtl/sbmel_serial_master.sv */
/*
 * Two-wire serial bus master with power-up EEPROM register loader and
 * byte-wide configuration registers at b0h..b3h.
 * Assumes open-drain pins resolved outside, a free-running link clock, and
 * a consumer of the load port that merges data under mask into its registers.
 */
// Functional notes
// RL1 - Detect flag at bit 3 is set when the interface is sensed; write 1 clears
// RL2 - Both power straps pulled up route clock to pin four, data to pin one
// RL3 - Clock toggles near 100 kHz in cycles; released and still while idle
// RL4 - EEPROM answers at address 1010000b; loader always uses it
// RL5 - Transfers open with data falling, close with data rising, clock high
// RL6 - Data line only changes while clock is low, except start and stop
// RL7 - Bytes are eight bits plus acknowledge, low through clock high
// RL8 - Device is sole master, standard mode, 7-bit addressing, 100 kb/s
// RL9 - Byte write sends start, address+0, index, data MSB first, stop
// RL10 - Missing address acknowledge sets error flag bit 6
// RL11 - Byte read uses direction 1; slave drives data, master drives clock
// RL12 - After reset, if detected, registers load from EEPROM; software cannot
// RL13 - Loader reads word address 00h first; FFh ends the list
// RL14 - Reference 01h loads 40h bits 31-0; 03h loads 8Ch bits 27-0
// RL15 - References 02h and 04h load only listed bits of 80h and 90h
// RL16 - Four bytes per entry MSB first, eight-byte stride, until terminator
// RL17 - Any undefined condition aborts loading and sets bit 0
// RL18 - Writing target select register starts a transaction
// RL19 - Index register is sent as the word address on byte transfers
// RL20 - Software loads data and index before writing target with direction 0
// RL21 - Reads poll busy bit 5; data register then holds the received byte
// RL22 - Reads send address+0 and index, repeated start, address+1, nack, stop
// RL23 - Doubleword read acknowledges three data bytes and not the fourth
module sbmel_serial_master (
	input  wire logic                     i_clk,
	input  wire logic                     i_nrst,
	input  wire logic                     i_link_clk,
	input  wire logic                     i_cfg_wr,
	input  wire logic [7:0]               i_cfg_addr,
	input  wire logic [7:0]               i_cfg_wdata,
	output logic      [7:0]               o_cfg_rdata,
	input  wire logic                     i_power_strap_a,
	input  wire logic                     i_power_strap_b,
	input  wire logic                     i_multi_pin_one_i,
	output logic                          o_multi_pin_one_o,
	output logic                          o_multi_pin_one_oe,
	output logic                          o_multi_pin_four_o,
	output logic                          o_multi_pin_four_oe,
	output logic                          o_iface_present,
	output sbmel_pkg::sbmel_load_type     o_load
);

	sbmel_pkg::sbmel_pstate_type     p_q;
	sbmel_pkg::sbmel_pstate_type     p_d;
	sbmel_pkg::sbmel_lstate_all_type l_q;
	sbmel_pkg::sbmel_lstate_all_type l_d;

	// ****************************************
	// Load target decode
	// ****************************************
	function automatic logic [7:0] ref_offset(input logic [7:0] r);
		logic [7:0] o;
		o = sbmel_pkg::PCI_OFS_COMBINED;
		if (r == sbmel_pkg::REF_SUBSYS_ID) begin
			o = sbmel_pkg::PCI_OFS_SUBSYS_ID;
		end else if (r == sbmel_pkg::REF_SYS_CTRL) begin
			o = sbmel_pkg::PCI_OFS_SYS_CTRL;
		end else if (r == sbmel_pkg::REF_MULTI_ROUTE) begin
			o = sbmel_pkg::PCI_OFS_MULTI_ROUTE;
		end
		return o;
	endfunction

	function automatic logic [31:0] ref_mask(input logic [7:0] r);
		logic [31:0] m;
		m = sbmel_pkg::MASK_COMBINED; // RL15
		if (r == sbmel_pkg::REF_SUBSYS_ID) begin
			m = sbmel_pkg::MASK_SUBSYS_ID; // RL14
		end else if (r == sbmel_pkg::REF_SYS_CTRL) begin
			m = sbmel_pkg::MASK_SYS_CTRL; // RL15
		end else if (r == sbmel_pkg::REF_MULTI_ROUTE) begin
			m = sbmel_pkg::MASK_MULTI_ROUTE; // RL14
		end
		return m;
	endfunction

	// ****************************************
	// Configuration side, system clock
	// ****************************************
	always_comb begin
		p_d = p_q;
		p_d.strap_a = {p_q.strap_a[0], i_power_strap_a};
		p_d.strap_b = {p_q.strap_b[0], i_power_strap_b};
		p_d.done_s = {p_q.done_s[1:0], l_q.done_tog};
		p_d.load_s = {p_q.load_s[1:0], l_q.load_tog};
		p_d.load.valid = 1'b0;
		if (p_q.init != sbmel_pkg::INIT_DONE) begin
			p_d.init = p_q.init + 2'h1;
		end
		if (i_cfg_wr) begin
			unique case (i_cfg_addr)
				sbmel_pkg::OFS_SERIAL_DATA_BYTE: begin
					p_d.data = i_cfg_wdata;
				end
				sbmel_pkg::OFS_SERIAL_WORD_INDEX: begin
					p_d.index = i_cfg_wdata;
				end
				sbmel_pkg::OFS_SERIAL_TARGET_SEL: begin
					p_d.tsel = i_cfg_wdata;
					if (!p_q.busy && p_q.present && p_q.init == sbmel_pkg::INIT_DONE) begin
						p_d.busy = 1'b1; // RL18
						p_d.req_tog = ~p_q.req_tog;
						p_d.cmd.is_load = 1'b0; // RL12
						p_d.cmd.is_read = i_cfg_wdata[sbmel_pkg::BIT_DIRECTION_SELECT]; // RL20
						p_d.cmd.addr = i_cfg_wdata[7:1];
						p_d.cmd.index = p_q.index; // RL19
						p_d.cmd.wdata = p_q.data;
					end
				end
				sbmel_pkg::OFS_SERIAL_CTRL_STATUS: begin
					if (i_cfg_wdata[sbmel_pkg::BIT_IFACE_PRESENT]) begin
						p_d.detect = 1'b0; // RL1
					end
					if (i_cfg_wdata[sbmel_pkg::BIT_LOAD_ERR]) begin
						p_d.load_err = 1'b0;
					end
					if (i_cfg_wdata[sbmel_pkg::BIT_NACK_ERR]) begin
						p_d.nack_err = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (p_q.init == sbmel_pkg::INIT_ACT) begin
			p_d.present = p_q.strap_a[1] & p_q.strap_b[1]; // RL2
			if (p_q.strap_a[1] & p_q.strap_b[1]) begin
				p_d.detect = 1'b1; // RL1
				p_d.busy = 1'b1; // RL12
				p_d.req_tog = ~p_q.req_tog;
				p_d.cmd.is_load = 1'b1;
				p_d.cmd.is_read = 1'b1;
				p_d.cmd.addr = sbmel_pkg::EEPROM_ADDR; // RL4
				p_d.cmd.index = sbmel_pkg::FIRST_WORD_ADDR; // RL13
				p_d.cmd.wdata = sbmel_pkg::RESET_REG;
			end
		end
		if (p_q.done_s[2] != p_q.done_s[1]) begin
			p_d.busy = 1'b0; // RL21
			if (!p_q.cmd.is_load && p_q.cmd.is_read) begin
				p_d.data = l_q.res.rx; // RL21
			end
			if (l_q.res.nack_err) begin
				p_d.nack_err = 1'b1; // RL10
			end
			if (l_q.res.load_err) begin
				p_d.load_err = 1'b1; // RL17
			end
		end
		if (p_q.load_s[2] != p_q.load_s[1]) begin
			p_d.load.valid = 1'b1;
			p_d.load.offset = ref_offset(l_q.ldw.ref_code);
			p_d.load.mask = ref_mask(l_q.ldw.ref_code);
			p_d.load.data = l_q.ldw.data & ref_mask(l_q.ldw.ref_code);
		end
		unique case (i_cfg_addr)
			sbmel_pkg::OFS_SERIAL_DATA_BYTE:   p_d.rdata = p_q.data;
			sbmel_pkg::OFS_SERIAL_WORD_INDEX:  p_d.rdata = p_q.index;
			sbmel_pkg::OFS_SERIAL_TARGET_SEL:  p_d.rdata = p_q.tsel;
			sbmel_pkg::OFS_SERIAL_CTRL_STATUS: p_d.rdata = {1'b0, p_q.nack_err, p_q.busy, 1'b0, p_q.detect,
				2'b00, p_q.load_err};
			default:                           p_d.rdata = sbmel_pkg::RESET_REG;
		endcase
		if (!i_nrst) begin
			p_d = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		p_q <= p_d;
	end

	// ****************************************
	// Link side, link clock
	// ****************************************
	logic tick;
	logic nack_slot;
	logic ref_ok;
	logic rd_step;

	always_comb begin
		l_d = l_q;
		tick = (l_q.qcnt == 7'h00);
		ref_ok = (l_q.rx > l_q.prev_ref) && (l_q.rx <= sbmel_pkg::REF_COMBINED); // RL17
		nack_slot = !l_q.cmd.is_load || ((l_q.nbyte == 3'h0) ? !ref_ok : (l_q.nbyte == sbmel_pkg::LAST_DATA_BYTE));
		rd_step = (l_q.step == sbmel_pkg::SP_RDATA);
		l_d.rst_s = {l_q.rst_s[0], i_nrst};
		l_d.req_s = {l_q.req_s[1:0], p_q.req_tog};
		l_d.sda_s = {l_q.sda_s[0], i_multi_pin_one_i};
		l_d.qcnt = tick ? sbmel_pkg::QUARTER_CYC - 7'h01 : l_q.qcnt - 7'h01; // RL3
		if (tick && l_q.st != sbmel_pkg::LS_IDLE) begin
			l_d.qph = l_q.qph + 2'h1;
		end
		unique case (l_q.st)
			sbmel_pkg::LS_IDLE: begin
				if (l_q.req_s[2] != l_q.req_s[1]) begin
					l_d.cmd = p_q.cmd;
					l_d.res = '0;
					l_d.finish = 1'b0;
					l_d.prev_ref = 8'h00;
					l_d.wa = p_q.cmd.index; // RL19
					l_d.st = sbmel_pkg::LS_START;
					l_d.step = sbmel_pkg::SP_ADDRW;
					l_d.txb = {p_q.cmd.addr, 1'b0}; // RL22
					l_d.nbyte = 3'h0;
					l_d.qph = 2'h0;
					l_d.qcnt = sbmel_pkg::QUARTER_CYC - 7'h01;
					l_d.scl = 1'b0;
				end
			end
			sbmel_pkg::LS_START: begin
				if (tick) begin
					unique case (l_q.qph)
						2'h0: l_d.sda = 1'b1;
						2'h1: l_d.scl = 1'b1;
						2'h2: l_d.sda = 1'b0; // RL5
						2'h3: begin
							l_d.scl = 1'b0;
							l_d.st = sbmel_pkg::LS_BYTE;
							l_d.bitn = sbmel_pkg::BITS_PER_SLOT;
						end
					endcase
				end
			end
			sbmel_pkg::LS_BYTE: begin
				if (tick) begin
					unique case (l_q.qph)
						2'h0: begin
							if (l_q.bitn != 4'h0) begin
								l_d.sda = rd_step ? 1'b1 : l_q.txb[7]; // RL6 RL9 RL11
							end else begin
								l_d.sda = rd_step ? nack_slot : 1'b1; // RL7 RL22 RL23
							end
						end
						2'h1: l_d.scl = 1'b1; // RL8
						2'h2: begin
							if (l_q.bitn != 4'h0) begin
								l_d.rx = {l_q.rx[6:0], l_q.sda_s[1]};
							end else begin
								l_d.acked = !l_q.sda_s[1]; // RL7
							end
						end
						2'h3: begin
							l_d.scl = 1'b0;
							l_d.txb = {l_q.txb[6:0], 1'b0};
							l_d.bitn = l_q.bitn - 4'h1;
							if (l_q.bitn == 4'h0) begin
								l_d.bitn = sbmel_pkg::BITS_PER_SLOT;
								l_d.st = sbmel_pkg::LS_STOP;
								if (rd_step) begin
									l_d.nbyte = l_q.nbyte + 3'h1;
									if (!l_q.cmd.is_load) begin
										l_d.res.rx = l_q.rx; // RL21
									end else if (l_q.nbyte == 3'h0) begin
										l_d.ref_code = l_q.rx;
										l_d.prev_ref = l_q.rx;
										if (l_q.rx == sbmel_pkg::LIST_TERMINATOR) begin
											l_d.finish = 1'b1; // RL13
										end else if (!ref_ok) begin
											l_d.finish = 1'b1;
											l_d.res.load_err = 1'b1; // RL17
										end else begin
											l_d.st = sbmel_pkg::LS_BYTE;
										end
									end else begin
										l_d.dword = {l_q.dword[23:0], l_q.rx}; // RL16
										if (l_q.nbyte == sbmel_pkg::LAST_DATA_BYTE) begin
											l_d.ldw = {l_q.ref_code, l_q.dword[23:0], l_q.rx};
											l_d.load_tog = ~l_q.load_tog;
										end else begin
											l_d.st = sbmel_pkg::LS_BYTE;
										end
									end
								end else if (!l_q.acked) begin
									if (l_q.step == sbmel_pkg::SP_ADDRW || l_q.step == sbmel_pkg::SP_ADDRR) begin
										l_d.res.nack_err = 1'b1; // RL10
									end
									if (l_q.cmd.is_load) begin
										l_d.res.load_err = 1'b1; // RL17
										l_d.finish = 1'b1;
									end
								end else begin
									unique case (l_q.step)
										sbmel_pkg::SP_ADDRW: begin
											l_d.st = sbmel_pkg::LS_BYTE;
											l_d.step = sbmel_pkg::SP_INDEX;
											l_d.txb = l_q.wa; // RL19
										end
										sbmel_pkg::SP_INDEX: begin
											if (l_q.cmd.is_read) begin
												l_d.st = sbmel_pkg::LS_START; // RL22
												l_d.step = sbmel_pkg::SP_ADDRR;
												l_d.txb = {l_q.cmd.addr, 1'b1}; // RL11
											end else begin
												l_d.st = sbmel_pkg::LS_BYTE;
												l_d.step = sbmel_pkg::SP_WDATA;
												l_d.txb = l_q.cmd.wdata; // RL9
											end
										end
										sbmel_pkg::SP_ADDRR: begin
											l_d.st = sbmel_pkg::LS_BYTE;
											l_d.step = sbmel_pkg::SP_RDATA;
											l_d.nbyte = 3'h0;
										end
										default: begin
										end
									endcase
								end
							end
						end
					endcase
				end
			end
			sbmel_pkg::LS_STOP: begin
				if (tick) begin
					unique case (l_q.qph)
						2'h0: l_d.sda = 1'b0;
						2'h1: l_d.scl = 1'b1;
						2'h2: l_d.sda = 1'b1; // RL5
						2'h3: begin
							if (l_q.cmd.is_load && !l_q.finish) begin
								l_d.wa = l_q.wa + sbmel_pkg::ENTRY_STRIDE; // RL16
								l_d.st = sbmel_pkg::LS_START;
								l_d.step = sbmel_pkg::SP_ADDRW;
								l_d.txb = {l_q.cmd.addr, 1'b0};
								l_d.nbyte = 3'h0;
								l_d.scl = 1'b0;
							end else begin
								l_d.st = sbmel_pkg::LS_IDLE; // RL3
								l_d.done_tog = ~l_q.done_tog;
							end
						end
					endcase
				end
			end
		endcase
		if (!l_q.rst_s[1]) begin
			l_d = '0;
			l_d.rst_s = {l_q.rst_s[0], i_nrst};
			l_d.scl = 1'b1;
			l_d.sda = 1'b1;
		end
	end

	always_ff @(posedge i_link_clk) begin
		l_q <= l_d;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign o_cfg_rdata = p_q.rdata;
	assign o_load = p_q.load;
	assign o_iface_present = p_q.present;
	assign o_multi_pin_one_o = 1'b0;
	assign o_multi_pin_one_oe = p_q.present & ~l_q.sda; // RL2
	assign o_multi_pin_four_o = 1'b0;
	assign o_multi_pin_four_oe = p_q.present & ~l_q.scl; // RL2 RL3

endmodule // sbmel_serial_master
